// *** rtl/iht_params.svh ***
// Register map, bit positions, vectors and timing counts of the
// interrupt and halt controller.
// Assumes inclusion by bare name from the package and the modules.
`ifndef IHT_PARAMS_SVH
`define IHT_PARAMS_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define IHT_ADDR_W        8
`define IHT_DATA_W        4
`define IHT_PC_W          12
`define IHT_NUM_PINS      4
`define IHT_NUM_TICKS     3
`define IHT_CNT_W         4

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define IHT_OFS_PIN_MASK  8'he8
`define IHT_OFS_TMR_MASK  8'heb
`define IHT_OFS_PIN_FLAG  8'hed
`define IHT_OFS_TMR_FLAG  8'hef

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define IHT_TICK_FASTEST  0
`define IHT_TICK_MIDDLE   1
`define IHT_TICK_SLOWEST  2
`define IHT_MASK_RST      4'h0
`define IHT_TMR_MASK_RST  3'h0
`define IHT_TMR_FLAG_RST  3'h0
`define IHT_FLAG_RST      1'b0
`define IHT_READ_ZERO     4'h0

// ----------------------------------------------------------------------
// Vectors on page 1, vectoring length in system clocks, edge-detector arm count
// ----------------------------------------------------------------------
`define IHT_VEC_PIN       12'h102
`define IHT_VEC_TMR       12'h104
`define IHT_SEQ_CYCLES    12
`define IHT_SYNC_ARM      2'h3

`endif

// *** rtl/iht_pkg.sv ***
// Types shared by the interrupt and halt controller modules.
// Assumes iht_params.svh supplies every width.
`include "iht_params.svh"

package iht_pkg;

    // Register bus request from the CPU
    typedef struct packed {
        logic [`IHT_ADDR_W-1:0] addr;
        logic [`IHT_DATA_W-1:0] wdata;
        logic                   wr;
        logic                   rd;
    } iht_bus_req_s;

    // Instruction-level controls from the CPU
    typedef struct packed {
        logic                 ei;
        logic                 di;
        logic                 halt;
        logic                 boundary;
        logic [`IHT_PC_W-1:0] pc_next;
    } iht_cpu_ctl_s;

    typedef enum logic [1:0] {
        IHT_SEQ_IDLE = 2'h0,
        IHT_SEQ_SAVE = 2'h1,
        IHT_SEQ_LOAD = 2'h3
    } iht_seq_e;

    typedef struct packed {
        iht_seq_e               state;
        logic [`IHT_CNT_W-1:0]  cnt;
        logic                   busy;
        logic                   push;
        logic                   load;
    } iht_seq_s;

    typedef struct packed {
        logic [`IHT_NUM_PINS-1:0]  pin_mask;
        logic [`IHT_NUM_TICKS-1:0] tmr_mask;
        logic                      pin_flag;
        logic [`IHT_NUM_PINS-1:0]  pin_rec;
        logic [`IHT_NUM_TICKS-1:0] tmr_flag;
        logic                      ie;
        logic                      running;
        logic                      irq;
        logic [`IHT_DATA_W-1:0]    rdata;
        logic [`IHT_PC_W-1:0]      vector;
        logic [`IHT_PC_W-1:0]      stack_data;
    } iht_ctl_s;

endpackage

// *** rtl/iht_edge_detect.sv ***
// Edge detector for a group of level inputs, one pulse per edge.
// Assumes SYNC=1 for pins from outside the clock domain.
`timescale 1ns/1ps
`include "iht_params.svh"

module iht_edge_detect
    import iht_pkg::*;
#(
    parameter int WIDTH  = 4,
    parameter bit SYNC   = 1'b1,
    parameter bit RISING = 1'b1
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             nrst_in,
    // Levels and edges
    input  wire logic [WIDTH-1:0] level_in,
    output logic      [WIDTH-1:0] edge_out
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] prev;
        logic [1:0]       arm;
        logic [WIDTH-1:0] edges;
    } iht_edge_state_s;

    iht_edge_state_s edge_reg;
    iht_edge_state_s edge_next;
    logic [WIDTH-1:0] sampled;

    if (WIDTH < 1) begin : g_chk
        $error("iht_edge_detect: WIDTH must be at least 1");
    end

    // Unsynchronised mode skips both stages; s1 feeds only s2
    assign sampled = SYNC ? edge_reg.s2 : level_in;

    always_comb begin
        edge_next      = edge_reg;
        edge_next.s1   = level_in;
        edge_next.s2   = edge_reg.s1;
        edge_next.prev = sampled;
        if (edge_reg.arm != `IHT_SYNC_ARM) begin
            edge_next.arm = edge_reg.arm + 2'h1;
        end
        // No edges until the pipeline holds real samples
        for (int i = 0; i < WIDTH; i++) begin
            edge_next.edges[i] = (edge_reg.arm == `IHT_SYNC_ARM) &&
                (RISING ? (sampled[i] & ~edge_reg.prev[i])
                        : (~sampled[i] & edge_reg.prev[i]));
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            edge_reg <= '0;
        end else begin
            edge_reg <= edge_next;
        end
    end

    assign edge_out = edge_reg.edges;

endmodule

// *** rtl/iht_vector_seq.sv ***
// Vectoring sequencer: stack-save pulse, then vector-load pulse.
// Assumes start_in is only raised while busy_out is low.
`timescale 1ns/1ps
`include "iht_params.svh"

module iht_vector_seq
    import iht_pkg::*;
#(
    parameter int SEQ_CYCLES = `IHT_SEQ_CYCLES
) (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic nrst_in,
    // Control
    input  wire logic start_in,
    output logic      busy_out,
    output logic      push_out,
    output logic      load_out
);

    localparam logic [`IHT_CNT_W-1:0] LAST =
        `IHT_CNT_W'(SEQ_CYCLES - 1);

    iht_seq_s seq_reg;
    iht_seq_s seq_next;

    if (SEQ_CYCLES < 3 || SEQ_CYCLES > 15) begin : g_chk
        $error("iht_vector_seq: SEQ_CYCLES must be 3 to 15");
    end

    always_comb begin
        seq_next      = seq_reg;
        seq_next.push = 1'b0;
        seq_next.load = 1'b0;
        case (seq_reg.state)
            IHT_SEQ_IDLE: begin
                if (start_in) begin
                    seq_next.state = IHT_SEQ_SAVE;
                    seq_next.cnt   = `IHT_CNT_W'(1);
                    seq_next.busy  = 1'b1;
                    seq_next.push  = 1'b1;
                end
            end
            IHT_SEQ_SAVE: begin
                seq_next.cnt = seq_reg.cnt + `IHT_CNT_W'(1);
                if (seq_reg.cnt == LAST) begin
                    seq_next.state = IHT_SEQ_LOAD;
                    seq_next.load  = 1'b1;
                end
            end
            IHT_SEQ_LOAD: begin
                seq_next.state = IHT_SEQ_IDLE;
                seq_next.cnt   = '0;
                seq_next.busy  = 1'b0;
            end
            default: begin
                seq_next = '0;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            seq_reg <= '0;
        end else begin
            seq_reg <= seq_next;
        end
    end

    assign busy_out = seq_reg.busy;
    assign push_out = seq_reg.push;
    assign load_out = seq_reg.load;

endmodule

// *** rtl/iht_controller.sv ***
// Interrupt and halt controller of a small 4-bit CPU: event flags,
// masks, global enable, halt wake-up and vectoring.
// Assumes tick inputs come from the clock timer on clk_in and the four
// input pins are asynchronous.
`timescale 1ns/1ps
`include "iht_params.svh"

// Contract
// - Each event flag sets on its own source event, independently.
// - Timer flags: slowest tick bit 2, middle bit 1, fastest bit 0.
// - Rising edge on any input pin sets the shared pin flag bit 0.
// - Request only when flag, its mask and global enable are all one.
// - Taking an interrupt clears the global enable.
// - Flag registers are read-only; reading returns then clears them.
// - All event flags are zero after reset.
// - Mask bits read and write; one enables; zero after reset.
// - Timer mask bits 0..2 fastest, middle, slowest; bit 3 reads zero.
// - Each pin has its own mask bit; only unmasked pins request.
// - Halt stops the CPU clock; any request restarts the CPU.
// - On accept, push next program counter then load a page-1 vector.
// - Save and vector load take exactly twelve system clocks.
// - Timer flags set even while masked; masks only block requests.
module iht_controller
    import iht_pkg::*;
#(
    parameter int NUM_PINS   = `IHT_NUM_PINS,
    parameter int SEQ_CYCLES = `IHT_SEQ_CYCLES
) (
    // Clock and reset
    input  wire logic                   clk_in,
    input  wire logic                   nrst_in,
    // Event sources
    input  wire logic                   tick_fastest_in,
    input  wire logic                   tick_middle_in,
    input  wire logic                   tick_slowest_in,
    input  wire logic [NUM_PINS-1:0]    input_pins_in,
    // Register port
    input  wire iht_bus_req_s           bus_in,
    output logic [`IHT_DATA_W-1:0]      rdata_out,
    // CPU control
    input  wire iht_cpu_ctl_s           cpu_in,
    output logic                        irq_out,
    output logic                        global_irq_enabled_out,
    output logic                        cpu_clk_run_out,
    // Vectoring
    output logic                        seq_busy_out,
    output logic                        stack_push_out,
    output logic [`IHT_PC_W-1:0]        stack_data_out,
    output logic                        vector_load_out,
    output logic [`IHT_PC_W-1:0]        vector_out
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (NUM_PINS != `IHT_NUM_PINS) begin : g_chk
        $error("iht_controller: NUM_PINS must match the pin mask");
    end

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    iht_ctl_s                   ctl_reg;
    iht_ctl_s                   ctl_next;
    logic [NUM_PINS-1:0]        pin_edge;
    logic [`IHT_NUM_TICKS-1:0]  tick_level;
    logic [`IHT_NUM_TICKS-1:0]  tick_edge;
    logic                       seq_busy;
    logic                       pin_req;
    logic                       tmr_req;
    logic                       pending;
    logic                       take;

    assign tick_level[`IHT_TICK_FASTEST] = tick_fastest_in;
    assign tick_level[`IHT_TICK_MIDDLE]  = tick_middle_in;
    assign tick_level[`IHT_TICK_SLOWEST] = tick_slowest_in;

    // ------------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------------
    // Pins are asynchronous, so they pass two stages first
    iht_edge_detect #(
        .WIDTH  (NUM_PINS),
        .SYNC   (1'b1),
        .RISING (1'b1)
    ) u_pin_edge (
        .clk_in   (clk_in),
        .nrst_in  (nrst_in),
        .level_in (input_pins_in),
        .edge_out (pin_edge)
    );

    // Timer ticks share this clock and interrupt on their falling edge
    iht_edge_detect #(
        .WIDTH  (`IHT_NUM_TICKS),
        .SYNC   (1'b0),
        .RISING (1'b0)
    ) u_tick_edge (
        .clk_in   (clk_in),
        .nrst_in  (nrst_in),
        .level_in (tick_level),
        .edge_out (tick_edge)
    );

    // ------------------------------------------------------------------
    // Vectoring sequencer
    // ------------------------------------------------------------------
    iht_vector_seq #(
        .SEQ_CYCLES (SEQ_CYCLES)
    ) u_seq (
        .clk_in   (clk_in),
        .nrst_in  (nrst_in),
        .start_in (take),
        .busy_out (seq_busy),
        .push_out (stack_push_out),
        .load_out (vector_load_out)
    );

    // ------------------------------------------------------------------
    // Request and acceptance
    // ------------------------------------------------------------------
    // The pin flag requests only through pins whose edge was recorded
    // and whose own mask is set
    assign pin_req = ctl_reg.pin_flag &
                     (|(ctl_reg.pin_rec & ctl_reg.pin_mask));
    assign tmr_req = |(ctl_reg.tmr_flag & ctl_reg.tmr_mask);
    assign pending = (pin_req | tmr_req) & ctl_reg.ie;
    // A halted CPU has no instruction boundary, so accept at once
    assign take    = pending & ~seq_busy &
                     (cpu_in.boundary | ~ctl_reg.running);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        ctl_next       = ctl_reg;
        ctl_next.rdata = `IHT_READ_ZERO;

        // Register reads; flags clear as they are read
        if (bus_in.rd) begin
            case (bus_in.addr)
                `IHT_OFS_PIN_MASK: begin
                    ctl_next.rdata = ctl_reg.pin_mask;
                end
                `IHT_OFS_TMR_MASK: begin
                    ctl_next.rdata = {1'b0, ctl_reg.tmr_mask};
                end
                `IHT_OFS_PIN_FLAG: begin
                    ctl_next.rdata    = {3'h0, ctl_reg.pin_flag};
                    ctl_next.pin_flag = `IHT_FLAG_RST;
                    ctl_next.pin_rec  = `IHT_MASK_RST;
                end
                `IHT_OFS_TMR_FLAG: begin
                    ctl_next.rdata    = {1'b0, ctl_reg.tmr_flag};
                    ctl_next.tmr_flag = `IHT_TMR_FLAG_RST;
                end
                default: begin
                    ctl_next.rdata = `IHT_READ_ZERO;
                end
            endcase
        end

        // Register writes; flag offsets ignore writes
        if (bus_in.wr) begin
            case (bus_in.addr)
                `IHT_OFS_PIN_MASK: begin
                    ctl_next.pin_mask = bus_in.wdata;
                end
                `IHT_OFS_TMR_MASK: begin
                    ctl_next.tmr_mask =
                        bus_in.wdata[`IHT_NUM_TICKS-1:0];
                end
                default: begin
                    ctl_next.pin_mask = ctl_next.pin_mask;
                end
            endcase
        end

        // Events are applied after the read-clear so they always win;
        // masks play no part here
        ctl_next.tmr_flag = ctl_next.tmr_flag | tick_edge;
        ctl_next.pin_rec  = ctl_next.pin_rec | pin_edge;
        if (|pin_edge) begin
            ctl_next.pin_flag = 1'b1;
        end

        // Global enable; disable and acceptance both beat enable
        if (cpu_in.ei) begin
            ctl_next.ie = 1'b1;
        end
        if (cpu_in.di || take) begin
            ctl_next.ie = 1'b0;
        end

        // Halt stops the CPU clock until a request arrives
        if (cpu_in.halt) begin
            ctl_next.running = 1'b0;
        end
        if (pending) begin
            ctl_next.running = 1'b1;
        end

        // Vector and saved address are captured at acceptance
        if (take) begin
            ctl_next.vector     = pin_req ? `IHT_VEC_PIN
                                          : `IHT_VEC_TMR;
            ctl_next.stack_data = cpu_in.pc_next;
        end

        ctl_next.irq = pending & ~take;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            ctl_reg            <= '0;
            ctl_reg.pin_mask   <= `IHT_MASK_RST;
            ctl_reg.tmr_mask   <= `IHT_TMR_MASK_RST;
            ctl_reg.pin_flag   <= `IHT_FLAG_RST;
            ctl_reg.tmr_flag   <= `IHT_TMR_FLAG_RST;
            ctl_reg.running    <= 1'b1;
        end else begin
            ctl_reg <= ctl_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rdata_out              = ctl_reg.rdata;
    assign irq_out                = ctl_reg.irq;
    assign global_irq_enabled_out = ctl_reg.ie;
    assign cpu_clk_run_out        = ctl_reg.running;
    assign seq_busy_out           = seq_busy;
    assign stack_data_out         = ctl_reg.stack_data;
    assign vector_out             = ctl_reg.vector;

endmodule

// *** verification/iht_controller_props.sv ***
// Port checker of the interrupt and halt controller.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
`include "iht_params.svh"

module iht_controller_props
    import iht_pkg::*;
#(
    parameter int NUM_PINS   = `IHT_NUM_PINS,
    parameter int SEQ_CYCLES = `IHT_SEQ_CYCLES
) (
    // Clock, reset, sources
    input wire logic                   clk_in,
    input wire logic                   nrst_in,
    input wire logic                   tick_fastest_in,
    input wire logic                   tick_middle_in,
    input wire logic                   tick_slowest_in,
    input wire logic [NUM_PINS-1:0]    input_pins_in,
    // Bus and CPU
    input wire iht_bus_req_s           bus_in,
    input wire logic [`IHT_DATA_W-1:0] rdata_out,
    input wire iht_cpu_ctl_s           cpu_in,
    input wire logic                   irq_out,
    input wire logic                   global_irq_enabled_out,
    input wire logic                   cpu_clk_run_out,
    // Vectoring
    input wire logic                   seq_busy_out,
    input wire logic                   stack_push_out,
    input wire logic [`IHT_PC_W-1:0]   stack_data_out,
    input wire logic                   vector_load_out,
    input wire logic [`IHT_PC_W-1:0]   vector_out
);
    localparam int LOAD_GAP = SEQ_CYCLES - 1;
    logic [4:0] busy_cnt_reg;

    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    // Counts busy cycles; the run length is judged when busy drops
    always_ff @(posedge clk_in) begin
        if (!nrst_in || !seq_busy_out) begin
            busy_cnt_reg <= 5'h0;
        end else begin
            busy_cnt_reg <= busy_cnt_reg + 5'h1;
        end
    end

    sequence s_take;
        $rose(seq_busy_out) && stack_push_out;
    endsequence

    property p_req_needs_ie;
        irq_out |-> global_irq_enabled_out || $past(global_irq_enabled_out);
    endproperty
    property p_take_clears_ie;
        s_take |-> !global_irq_enabled_out && !irq_out;
    endproperty
    property p_ie_stays_off;
        !global_irq_enabled_out && !cpu_in.ei |=> !global_irq_enabled_out;
    endproperty
    property p_push_first;
        $rose(seq_busy_out) |-> stack_push_out && !vector_load_out;
    endproperty
    property p_load_after_push;
        s_take |-> ##LOAD_GAP vector_load_out;
    endproperty
    property p_vec_page1;
        vector_load_out |-> vector_out[11:8] == 4'h1
            && vector_out[7:0] inside {[8'h01:8'h07]};
    endproperty
    property p_busy_len;
        $fell(seq_busy_out) |-> busy_cnt_reg == SEQ_CYCLES;
    endproperty
    property p_halt_stops;
        $fell(cpu_clk_run_out) |-> $past(cpu_in.halt);
    endproperty
    property p_wake_takes;
        $rose(cpu_clk_run_out) |-> $rose(seq_busy_out);
    endproperty
    property p_rdata_only_read;
        rdata_out != 4'h0 |-> $past(bus_in.rd);
    endproperty
    property p_tmask_top_zero;
        $past(bus_in.rd) && $past(bus_in.addr) == `IHT_OFS_TMR_MASK
            |-> !rdata_out[3];
    endproperty

    a_req_needs_ie: assert property (p_req_needs_ie)
        else $error("request without global enable");
    a_take_clears_ie: assert property (p_take_clears_ie)
        else $error("enable not cleared on take");
    a_ie_stays_off: assert property (p_ie_stays_off)
        else $error("enable set without ei");
    a_push_first: assert property (p_push_first)
        else $error("vectoring did not start with push");
    a_load_after_push: assert property (p_load_after_push)
        else $error("vector load not at end of sequence");
    a_vec_page1: assert property (p_vec_page1)
        else $error("vector outside page 1 range");
    a_busy_len: assert property (p_busy_len)
        else $error("vectoring length wrong");
    a_halt_stops: assert property (p_halt_stops)
        else $error("clock stopped without halt");
    a_wake_takes: assert property (p_wake_takes)
        else $error("wake without request");
    a_rdata_only_read: assert property (p_rdata_only_read)
        else $error("read data outside read answer");
    a_tmask_top_zero: assert property (p_tmask_top_zero)
        else $error("timer mask bit 3 not zero");
endmodule

bind iht_controller iht_controller_props #(
    .NUM_PINS(NUM_PINS), .SEQ_CYCLES(SEQ_CYCLES)
) i_props (
    .clk_in(clk_in), .nrst_in(nrst_in),
    .tick_fastest_in(tick_fastest_in), .tick_middle_in(tick_middle_in),
    .tick_slowest_in(tick_slowest_in), .input_pins_in(input_pins_in),
    .bus_in(bus_in), .rdata_out(rdata_out), .cpu_in(cpu_in),
    .irq_out(irq_out), .global_irq_enabled_out(global_irq_enabled_out),
    .cpu_clk_run_out(cpu_clk_run_out), .seq_busy_out(seq_busy_out),
    .stack_push_out(stack_push_out), .stack_data_out(stack_data_out),
    .vector_load_out(vector_load_out), .vector_out(vector_out)
);

// *** verification/iht_cpu_model.sv ***
// Behavioural CPU core facing the controller.
// Assumes the bench supplies ei, di and halt as one-cycle pulses.
`timescale 1ns/1ps
`include "iht_params.svh"

module iht_cpu_model
    import iht_pkg::*;
#(
    parameter logic [11:0] START_PC = 12'h200
) (
    // Clock, reset, instruction pulses
    input  wire logic                 clk_in,
    input  wire logic                 nrst_in,
    input  wire logic                 ei_in,
    input  wire logic                 di_in,
    input  wire logic                 halt_in,
    // Controller status
    input  wire logic                 run_in,
    input  wire logic                 busy_in,
    input  wire logic                 load_in,
    input  wire logic [`IHT_PC_W-1:0] vector_in,
    // Core controls
    output iht_cpu_ctl_s              cpu_out
);
    logic [`IHT_PC_W-1:0] pc_reg;

    // Program counter stalls while halted or while vectoring
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            pc_reg <= START_PC;
        end else if (load_in) begin
            pc_reg <= vector_in;
        end else if (run_in && !busy_in) begin
            pc_reg <= pc_reg + 12'h001;
        end
    end

    assign cpu_out.ei = ei_in;
    assign cpu_out.di = di_in;
    assign cpu_out.halt = halt_in;
    assign cpu_out.boundary = run_in && !busy_in;
    assign cpu_out.pc_next = pc_reg;
endmodule

// *** verification/interrupt_halt_controller_tb_top.sv ***
// Self-checking bench of the interrupt and halt controller.
// Assumes the default sequence length of twelve cycles.
`timescale 1ns/1ps
`include "iht_params.svh"

module interrupt_halt_controller_tb_top
    import iht_pkg::*;
;
    typedef struct packed {
        logic [7:0] a;
        logic [3:0] w;
        logic [3:0] e;
    } iht_row_s;

    localparam logic [7:0] PM = `IHT_OFS_PIN_MASK;
    localparam logic [7:0] TM = `IHT_OFS_TMR_MASK;
    localparam logic [7:0] PF = `IHT_OFS_PIN_FLAG;
    localparam logic [7:0] TF = `IHT_OFS_TMR_FLAG;

    logic         clk_in = 1'b0;
    logic         nrst_in = 1'b0;
    logic [2:0]   ticks = 3'h7;
    logic [3:0]   pins = 4'h0;
    logic [2:0]   ctl = 3'h0;
    iht_bus_req_s bus = '0;
    iht_cpu_ctl_s cpu;
    logic [3:0]   rdata;
    logic [3:0]   d;
    logic         irq, ie, run, busy, push, load;
    logic [11:0]  sdata, vec;
    int           miscompares = 0;
    int           n_checks = 0;
    iht_row_s     rows [8] = '{'{PM, 4'hf, 4'hf}, '{PM, 4'h5, 4'h5},
        '{TM, 4'hf, 4'h7}, '{PF, 4'hf, 4'h0}, '{TF, 4'h7, 4'h0},
        '{8'h10, 4'hf, 4'h0}, '{TM, 4'h0, 4'h0}, '{PM, 4'h0, 4'h0}};

    always #2.5 clk_in = ~clk_in;

    iht_controller i_dut (
        .clk_in(clk_in), .nrst_in(nrst_in),
        .tick_fastest_in(ticks[0]), .tick_middle_in(ticks[1]),
        .tick_slowest_in(ticks[2]), .input_pins_in(pins),
        .bus_in(bus), .rdata_out(rdata), .cpu_in(cpu), .irq_out(irq),
        .global_irq_enabled_out(ie), .cpu_clk_run_out(run),
        .seq_busy_out(busy), .stack_push_out(push),
        .stack_data_out(sdata), .vector_load_out(load),
        .vector_out(vec)
    );

    iht_cpu_model i_cpu (
        .clk_in(clk_in), .nrst_in(nrst_in), .ei_in(ctl[0]),
        .di_in(ctl[1]), .halt_in(ctl[2]), .run_in(run), .busy_in(busy),
        .load_in(load), .vector_in(vec), .cpu_out(cpu)
    );

    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] w);
        @(posedge clk_in);
        bus <= '{a, w, 1'b1, 1'b0};
        @(posedge clk_in);
        bus.wr <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [3:0] e);
        @(posedge clk_in);
        bus <= '{a, 4'h0, 1'b0, 1'b1};
        @(posedge clk_in);
        bus.rd <= 1'b0;
        #1 d = rdata;
        chk(d, e);
    endtask

    task automatic pulse(input logic [2:0] c);
        @(posedge clk_in);
        ctl <= c;
        @(posedge clk_in);
        ctl <= 3'h0;
    endtask

    // Halted takes capture an unadvanced counter, hence back = 0
    task automatic take(input logic [11:0] v, input logic [11:0] back);
        int n;
        n = 0;
        while (push !== 1'b1 && n < 60) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        if (push !== 1'b1) begin
            miscompares++;
            end_sim();
        end
        chk(sdata, cpu.pc_next - back);
        chk(vec, v);
        chk(ie, 1'b0);
        repeat (`IHT_SEQ_CYCLES - 1) @(posedge clk_in);
        #1 chk(load, 1'b1);
        @(posedge clk_in);
        #1 chk(cpu.pc_next, v);
    endtask

    initial begin
        repeat (16) @(posedge clk_in);
        nrst_in <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rdc(rows[i].a, rows[i].e);
        end
        pulse(3'h1);
        #1 chk(ie, 1'b1);
        pulse(3'h3);
        #1 chk(ie, 1'b0);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_in);
            ticks[i] <= 1'b0;
            repeat (4) @(posedge clk_in);
            rdc(TF, 4'h1 << i);
            chk(irq, 1'b0);
            rdc(TF, 4'h0);
            ticks[i] <= 1'b1;
        end
        @(posedge clk_in);
        ticks[0] <= 1'b0;
        rdc(TF, 4'h0);
        rdc(TF, 4'h1);
        ticks[0] <= 1'b1;
        wr(PM, 4'h4);
        pulse(3'h1);
        pins <= 4'h1;
        repeat (10) @(posedge clk_in);
        #1 chk(irq, 1'b0);
        pins <= 4'h5;
        take(`IHT_VEC_PIN, 12'h1);
        rdc(PF, 4'h1);
        pins <= 4'h0;
        wr(PM, 4'h1);
        wr(TM, 4'h1);
        repeat (6) @(posedge clk_in);
        pins <= 4'h1;
        ticks[0] <= 1'b0;
        repeat (10) @(posedge clk_in);
        ticks[0] <= 1'b1;
        pulse(3'h1);
        // Enable again mid-vectoring: the timer request must wait
        fork
            take(`IHT_VEC_PIN, 12'h1);
            begin
                repeat (2) @(posedge clk_in);
                rdc(PF, 4'h1);
                pulse(3'h1);
                @(posedge clk_in);
                #1 chk(irq, 1'b1);
            end
        join
        take(`IHT_VEC_TMR, 12'h1);
        rdc(TF, 4'h1);
        pulse(3'h1);
        pulse(3'h4);
        repeat (4) @(posedge clk_in);
        #1 chk(run, 1'b0);
        ticks[0] <= 1'b0;
        take(`IHT_VEC_TMR, 12'h0);
        chk(run, 1'b1);
        ticks[0] <= 1'b1;
        wr(PM, 4'hf);
        wr(TM, 4'h7);
        ticks[1] <= 1'b0;
        repeat (6) @(posedge clk_in);
        nrst_in <= 1'b0;
        repeat (16) @(posedge clk_in);
        nrst_in <= 1'b1;
        ticks[1] <= 1'b1;
        rdc(PM, 4'h0);
        rdc(TM, 4'h0);
        rdc(PF, 4'h0);
        rdc(TF, 4'h0);
        chk({ie, run}, 2'h1);
        end_sim();
    end
endmodule
